// *** logic/imupr_pkg.sv ***
// constants and register map for the interrupt pin router
// Behaviour
// - motion interrupts come from accelerometer data; only gyro may be powered down
// - in i3c mode pins go active only when i3c_pin_enable is set; end-of-operation level ignores it
// - pin_polarity_low 0 idles low, raises on event; 1 idles high, falls
// - pin_open_drain 0 drives both levels; 1 drives only the active level
// - first-pin fifo/drdy routing bits 6,5,4,3,1,0; bits 7 and 2 read 0
// - first-pin motion routing bits 7 down to 1; bit 0 reads 0
// - second-pin fifo/drdy routing as first, bit 7 routes end-of-operation
// - second-pin motion routing as first, bit 0 routes timestamp overflow
// - all routing bits reset to 0; only a written 1 routes a source
// - end-of-operation mode: pin low while embedded work runs, high otherwise
// - own bits route temperature and front-end data-ready to second pin
// - pin active state is OR of all enabled routed sources
// - aggregate source register gathers basic and embedded event flags
// - redirect_to_first_pin moves movable second-pin sources onto first pin
// - basic motion interrupts suppressed unless basic_irq_enable is set
// - latched basic event stays asserted until a source register read or until basic_irq_enable is cleared
// - only an event routed to some pin is latched
// - no_clear_on_aggregate_read stops aggregate reads clearing latches
// - data-ready latches until high byte read; pulse mode gives 65 us pulse
// - unlatched basic events follow their detector condition
package imupr_pkg;
    // byte addresses of the registers
    localparam logic [7:0] OFS_P1_FIFO_DRDY = 8'h00;
    localparam logic [7:0] OFS_P1_MOTION    = 8'h04;
    localparam logic [7:0] OFS_P2_FIFO_DRDY = 8'h08;
    localparam logic [7:0] OFS_P2_MOTION    = 8'h0c;
    localparam logic [7:0] OFS_PIN_CONFIG   = 8'h10;
    localparam logic [7:0] OFS_AGGREGATE    = 8'h14;
    localparam logic [7:0] OFS_WAKE_SRC     = 8'h18;
    localparam logic [7:0] OFS_TAP_SOURCE_REG      = 8'h1c;
    localparam logic [7:0] OFS_ORIENT_SRC   = 8'h20;
    localparam logic [7:0] OFS_DRDY_STATUS  = 8'h24;
    // writable masks and reset values
    localparam logic [7:0] FIFO_DRDY_MASK1  = 8'h7b;
    localparam logic [7:0] FIFO_DRDY_MASK2  = 8'hfb;
    localparam logic [7:0] MOTION_MASK1     = 8'hfe;
    localparam logic [7:0] MOTION_MASK2     = 8'hff;
    localparam logic [7:0] ROUTE_RESET      = 8'h00;
    localparam logic [9:0] CONFIG_RESET     = 10'h000;
    // pin_config fields
    localparam int CFG_POL_LOW = 0;
    localparam int CFG_OPEN_DRAIN = 1;
    localparam int CFG_I3C_PIN_EN = 2;
    localparam int CFG_REDIRECT = 3;
    localparam int CFG_LATCH_EN = 4;
    localparam int CFG_NO_AGG_CLR = 5;
    localparam int CFG_BASIC_EN = 6;
    localparam int CFG_DRDY_PULSE = 7;
    localparam int CFG_P2_TEMP = 8;
    localparam int CFG_P2_FRONTEND = 9;
    // fifo/drdy routing fields
    localparam int FD_ACCEL = 0;
    localparam int FD_GYRO = 1;
    localparam int FD_THRESH = 3;
    localparam int FD_OVERRUN = 4;
    localparam int FD_FULL = 5;
    localparam int FD_BATCH = 6;
    localparam int FD_ENDOP = 7;
    // motion routing fields
    localparam int MO_STAMP = 0;
    localparam int MO_EMBED = 1;
    localparam int MO_ORIENT = 2;
    localparam int MO_DTAP = 3;
    localparam int MO_FREEFALL = 4;
    localparam int MO_WAKEUP = 5;
    localparam int MO_STAP = 6;
    localparam int MO_ACTIVITY = 7;
    // data-ready pulse length
    localparam int CLK_PERIOD_NS = 10;
    localparam int DRDY_PULSE_NS = 65000;
    localparam int DRDY_PULSE_CYC = DRDY_PULSE_NS / CLK_PERIOD_NS;
endpackage

// *** logic/imupr_router.sv ***
// interrupt routing, latching, pin drive and ahb-lite register slave
`timescale 1ns/10ps
module imupr_router #(
    parameter int PULSE_CYC = imupr_pkg::DRDY_PULSE_CYC
) (
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    input  wire logic        accel_active_in,
    input  wire logic        i3c_mode_in,
    input  wire logic [5:0]  basic_event_in,
    input  wire logic        embedded_event_in,
    input  wire logic        embedded_running_in,
    input  wire logic        stamp_overflow_in,
    input  wire logic        temperature_ready_in,
    input  wire logic        frontend_ready_in,
    input  wire logic [3:0]  fifo_flag_in,
    input  wire logic        accel_ready_in,
    input  wire logic        gyro_ready_in,
    input  wire logic        accel_high_read_in,
    input  wire logic        gyro_high_read_in,
    output logic             first_irq_pin_out,
    output logic             first_irq_pin_oe_out,
    output logic             second_irq_pin_out,
    output logic             second_irq_pin_oe_out
);
    // basic_event_in: 0 freefall, 1 wakeup, 2 single tap, 3 double tap, 4 orientation, 5 activity
    // fifo_flag_in: 0 threshold, 1 overrun, 2 full, 3 batch counter

    ////////////////////////////////////////////////////////////////////////////////
    // software-visible state
    logic [7:0] pin1_fifo_drdy_route;
    logic [7:0] pin1_motion_route;
    logic [7:0] pin2_fifo_drdy_route;
    logic [7:0] pin2_motion_route;
    logic [9:0] pin_config;
    logic [5:0] basic_latch;
    logic [1:0] drdy_flag;
    logic [1:0] drdy_pulse;
    logic [31:0] pulse_cnt [2];

    // bus side
    logic        wr_pending;
    logic [7:0]  wr_addr;
    logic        rd_take;
    logic [7:0]  rd_addr;
    logic [31:0] rd_value;

    // decode, routing and pin activity
    logic        clr_agg;
    logic        clr_wake;
    logic        clr_tap;
    logic        clr_orient;
    logic [5:0]  basic_clr;
    logic [5:0]  routed1;
    logic [5:0]  routed2;
    logic [5:0]  basic_live;
    logic [5:0]  basic_eff;
    logic [1:0]  drdy_src;
    logic [6:0]  agg_flags;
    logic        pins_allowed;
    logic        movable;
    logic        act1;
    logic        act2;
    logic        endop1;
    logic        endop2;

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite: zero wait states, always okay
    assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;

    // a constant-ready slave never makes the master wait
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else
        begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // address phase capture for writes, data lands one edge later
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
        end
        else
        begin
            wr_pending <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[31:8] == 24'h000000;
            wr_addr    <= haddr_in[7:0];
        end
    end

    // read data registered at the address phase edge; unmapped reads give zero
    always_comb
    begin
        rd_addr = haddr_in[7:0];
        rd_value = 32'h0000_0000;
        if (haddr_in[31:8] == 24'h000000)
        begin
            case (rd_addr)
                imupr_pkg::OFS_P1_FIFO_DRDY: rd_value = {24'h000000, pin1_fifo_drdy_route};
                imupr_pkg::OFS_P1_MOTION:    rd_value = {24'h000000, pin1_motion_route};
                imupr_pkg::OFS_P2_FIFO_DRDY: rd_value = {24'h000000, pin2_fifo_drdy_route};
                imupr_pkg::OFS_P2_MOTION:    rd_value = {24'h000000, pin2_motion_route};
                imupr_pkg::OFS_PIN_CONFIG:   rd_value = {22'h0, pin_config};
                imupr_pkg::OFS_AGGREGATE:    rd_value = {25'h0, agg_flags};
                imupr_pkg::OFS_WAKE_SRC:     rd_value = {29'h0, basic_eff[5], basic_eff[1:0]};
                imupr_pkg::OFS_TAP_SOURCE_REG:      rd_value = {30'h0, basic_eff[3:2]};
                imupr_pkg::OFS_ORIENT_SRC:   rd_value = {31'h0, basic_eff[4]};
                imupr_pkg::OFS_DRDY_STATUS:  rd_value = {30'h0, drdy_flag};
                default:                     rd_value = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            hrdata_out <= 32'h0000_0000;
        else if (rd_take)
            hrdata_out <= rd_value;
    end

    // control registers; reserved bits are held at zero
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin1_fifo_drdy_route <= imupr_pkg::ROUTE_RESET;
            pin1_motion_route    <= imupr_pkg::ROUTE_RESET;
            pin2_fifo_drdy_route <= imupr_pkg::ROUTE_RESET;
            pin2_motion_route    <= imupr_pkg::ROUTE_RESET;
            pin_config           <= imupr_pkg::CONFIG_RESET;
        end
        else if (wr_pending)
        begin
            case (wr_addr)
                imupr_pkg::OFS_P1_FIFO_DRDY: pin1_fifo_drdy_route <= hwdata_in[7:0] & imupr_pkg::FIFO_DRDY_MASK1;
                imupr_pkg::OFS_P1_MOTION:    pin1_motion_route <= hwdata_in[7:0] & imupr_pkg::MOTION_MASK1;
                imupr_pkg::OFS_P2_FIFO_DRDY: pin2_fifo_drdy_route <= hwdata_in[7:0] & imupr_pkg::FIFO_DRDY_MASK2;
                imupr_pkg::OFS_P2_MOTION:    pin2_motion_route <= hwdata_in[7:0] & imupr_pkg::MOTION_MASK2;
                imupr_pkg::OFS_PIN_CONFIG:   pin_config <= hwdata_in[9:0];
                default:                     pin_config <= pin_config;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read side effects: source reads clear their latches
    assign clr_agg    = rd_take && rd_addr == imupr_pkg::OFS_AGGREGATE && !pin_config[imupr_pkg::CFG_NO_AGG_CLR];
    assign clr_wake   = rd_take && rd_addr == imupr_pkg::OFS_WAKE_SRC;
    assign clr_tap    = rd_take && rd_addr == imupr_pkg::OFS_TAP_SOURCE_REG;
    assign clr_orient = rd_take && rd_addr == imupr_pkg::OFS_ORIENT_SRC;
    assign basic_clr  = {clr_wake, clr_orient, clr_tap, clr_tap, clr_wake, clr_wake} | {6{clr_agg}};

    // routing of each basic event, in basic_event_in order
    assign routed1 = {pin1_motion_route[imupr_pkg::MO_ACTIVITY], pin1_motion_route[imupr_pkg::MO_ORIENT],
                      pin1_motion_route[imupr_pkg::MO_DTAP], pin1_motion_route[imupr_pkg::MO_STAP],
                      pin1_motion_route[imupr_pkg::MO_WAKEUP], pin1_motion_route[imupr_pkg::MO_FREEFALL]};
    assign routed2 = {pin2_motion_route[imupr_pkg::MO_ACTIVITY], pin2_motion_route[imupr_pkg::MO_ORIENT],
                      pin2_motion_route[imupr_pkg::MO_DTAP], pin2_motion_route[imupr_pkg::MO_STAP],
                      pin2_motion_route[imupr_pkg::MO_WAKEUP], pin2_motion_route[imupr_pkg::MO_FREEFALL]};

    // detectors only work on accelerometer data, so a powered-down accel yields nothing
    assign basic_live = basic_event_in & {6{accel_active_in && pin_config[imupr_pkg::CFG_BASIC_EN]}};

    // latch only routed events; a new event beats a clearing read
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            basic_latch <= 6'h00;
        else
            basic_latch <= (basic_latch & ~basic_clr & {6{pin_config[imupr_pkg::CFG_BASIC_EN]}})
                         | (basic_live & (routed1 | routed2) & {6{pin_config[imupr_pkg::CFG_LATCH_EN]}});
    end

    // unlatched events track the detector directly
    // clearing basic_irq_enable also hides and clears any pending latch
    assign basic_eff = {6{pin_config[imupr_pkg::CFG_BASIC_EN]}}
                     & (pin_config[imupr_pkg::CFG_LATCH_EN] ? (basic_latch | basic_live) : basic_live);
    assign agg_flags = {embedded_event_in, basic_eff};

    ////////////////////////////////////////////////////////////////////////////////
    // data-ready flags stay latched; pulse mode only shapes the pin
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            drdy_flag <= 2'b00;
        else
            drdy_flag <= (drdy_flag & ~{gyro_high_read_in, accel_high_read_in})
                       | {gyro_ready_in, accel_ready_in};
    end

    // one pulse counter per data-ready source; a new sample restarts it
    // samples closer than the pulse length merge into one long pulse
    for (genvar i = 0; i < 2; i++)
    begin : g_pulse
        always_ff @(posedge mclk_in or negedge resetn_in)
        begin
            if (!resetn_in)
                pulse_cnt[i] <= 32'h0000_0000;
            else if (i == 0 ? accel_ready_in : gyro_ready_in)
                pulse_cnt[i] <= 32'(PULSE_CYC);
            else if (pulse_cnt[i] != 32'h0000_0000)
                pulse_cnt[i] <= pulse_cnt[i] - 32'h0000_0001;
        end
        assign drdy_pulse[i] = pulse_cnt[i] != 32'h0000_0000;
    end

    assign drdy_src = pin_config[imupr_pkg::CFG_DRDY_PULSE] ? drdy_pulse : drdy_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // pin activity: OR of routed sources, evaluated every cycle
    assign pins_allowed = !i3c_mode_in || pin_config[imupr_pkg::CFG_I3C_PIN_EN];
    assign movable = (pin2_motion_route[imupr_pkg::MO_STAMP] & stamp_overflow_in)
                   | (pin_config[imupr_pkg::CFG_P2_TEMP] & temperature_ready_in)
                   | (pin_config[imupr_pkg::CFG_P2_FRONTEND] & frontend_ready_in);
    assign endop1 = pin2_fifo_drdy_route[imupr_pkg::FD_ENDOP] && pin_config[imupr_pkg::CFG_REDIRECT];
    assign endop2 = pin2_fifo_drdy_route[imupr_pkg::FD_ENDOP] && !pin_config[imupr_pkg::CFG_REDIRECT];

    assign act1 = |(basic_eff & routed1)
                | (pin1_motion_route[imupr_pkg::MO_EMBED] & embedded_event_in)
                | |(pin1_fifo_drdy_route[6:3] & fifo_flag_in)
                | |(pin1_fifo_drdy_route[1:0] & drdy_src)
                | (pin_config[imupr_pkg::CFG_REDIRECT] & movable);
    assign act2 = |(basic_eff & routed2)
                | (pin2_motion_route[imupr_pkg::MO_EMBED] & embedded_event_in)
                | |(pin2_fifo_drdy_route[6:3] & fifo_flag_in)
                | |(pin2_fifo_drdy_route[1:0] & drdy_src)
                | (!pin_config[imupr_pkg::CFG_REDIRECT] & movable);

    // open drain: the inactive level is left to the external pull resistor
    // polarity then drive mode; end-of-operation forces a raw level and always drives
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            first_irq_pin_out     <= 1'b0;
            first_irq_pin_oe_out  <= 1'b1;
            second_irq_pin_out    <= 1'b0;
            second_irq_pin_oe_out <= 1'b1;
        end
        else
        begin
            if (endop1)
            begin
                first_irq_pin_out    <= !embedded_running_in;
                first_irq_pin_oe_out <= 1'b1;
            end
            else
            begin
                first_irq_pin_out    <= (act1 && pins_allowed) ^ pin_config[imupr_pkg::CFG_POL_LOW];
                first_irq_pin_oe_out <= !pin_config[imupr_pkg::CFG_OPEN_DRAIN] || (act1 && pins_allowed);
            end

            if (endop2)
            begin
                second_irq_pin_out    <= !embedded_running_in;
                second_irq_pin_oe_out <= 1'b1;
            end
            else
            begin
                second_irq_pin_out    <= (act2 && pins_allowed) ^ pin_config[imupr_pkg::CFG_POL_LOW];
                second_irq_pin_oe_out <= !pin_config[imupr_pkg::CFG_OPEN_DRAIN] || (act2 && pins_allowed);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks next to the logic they guard
    a_pin_polarity: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !endop1
        |=> first_irq_pin_out == ($past(act1 && pins_allowed) ^ $past(pin_config[0])))
        else $error("first pin level does not follow activity and polarity");

    a_open_drain_release: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (pin_config[1] && !act2 && !endop2)
        |=> !second_irq_pin_oe_out)
        else $error("open drain pin driven at inactive level");

    a_route_or_pin: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (pins_allowed && !endop2 && |(pin2_fifo_drdy_route[6:3] & fifo_flag_in))
        |=> second_irq_pin_out != $past(pin_config[0]))
        else $error("routed fifo flag did not reach second pin");

    a_latch_holds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (basic_latch[0] && !basic_clr[0] && pin_config[6])
        |=> basic_latch[0])
        else $error("latched freefall lost without a clearing read");

    a_unrouted_no_latch: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!basic_latch[1] && !routed1[1] && !routed2[1])
        |=> !basic_latch[1])
        else $error("unrouted wakeup was latched");

    a_basic_gate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !pin_config[6]
        |-> basic_eff == 6'h00 ##1 basic_latch == 6'h00)
        else $error("basic event passed while globally disabled");

    a_agg_no_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (pin_config[5] && pin_config[6] && rd_take && rd_addr == 8'h14 && basic_latch[2])
        |=> basic_latch[2])
        else $error("aggregate read cleared latch despite no-clear setting");

    a_drdy_pulse_len: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (accel_ready_in && PULSE_CYC > 8)
        |=> drdy_pulse[0] [*8])
        else $error("data-ready pulse shorter than expected");

    a_i3c_gate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (i3c_mode_in && !pin_config[2] && !endop1)
        |=> first_irq_pin_out == $past(pin_config[0]))
        else $error("pin active in i3c mode without pin enable");

    a_endop_level: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        endop2
        |=> second_irq_pin_out == !$past(embedded_running_in))
        else $error("end-of-operation level wrong on second pin");

    a_endop_redirect: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        endop1
        |=> first_irq_pin_out == !$past(embedded_running_in))
        else $error("end-of-operation level wrong on first pin");

endmodule // imupr_router

// *** testbench/imu_interrupt_pin_router_test.sv ***
// self-checking bench for the interrupt pin router
`timescale 1ns/10ps
module imu_interrupt_pin_router_test;
    localparam int PULSE = 20; // short data-ready pulse keeps the run brief
    localparam logic [7:0] MSK [4] = '{imupr_pkg::FIFO_DRDY_MASK1, imupr_pkg::MOTION_MASK1,
                                       imupr_pkg::FIFO_DRDY_MASK2, imupr_pkg::MOTION_MASK2};
    logic        mclk_in, resetn_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [5:0]  basic_event_in;
    logic [3:0]  fifo_flag_in;
    logic        accel_active_in, i3c_mode_in, embedded_event_in, embedded_running_in, stamp_overflow_in;
    logic        temperature_ready_in, frontend_ready_in, accel_ready_in, gyro_ready_in, gyro_high_read_in;
    logic        accel_high_read_in, first_irq_pin_out, first_irq_pin_oe_out, second_irq_pin_out;
    logic        second_irq_pin_oe_out, line1, line2;
    logic [9:0]  cfg;
    logic [7:0]  rt [4];
    logic [8:0]  src;
    integer      seed, miscompares, n_tests, i, j, e;

    ////////////////////////////////////////////////////////////////////////////////
    // design, host wires and clock
    assign hready_in = hreadyout_out; // single slave drives the bus ready
    imupr_router #(.PULSE_CYC(PULSE)) i_dut (.*);
    imupr_host_model i_host (.first_pin_in(first_irq_pin_out), .first_oe_in(first_irq_pin_oe_out),
        .second_pin_in(second_irq_pin_out), .second_oe_in(second_irq_pin_oe_out), .pol_low_in(cfg[0]),
        .first_line_out(line1), .second_line_out(line2));
    always #5 mclk_in = ~mclk_in;

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one ahb-lite single transfer; ends just after an idle cycle so reads see prior writes
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel_in   <= 1'b1;
        haddr_in  <= {24'h000000, a};
        hwrite_in <= w;
        htrans_in <= 2'b10;
        @(posedge mclk_in);
        while (hready_in !== 1'b1) @(posedge mclk_in);
        htrans_in <= 2'b00;
        hwdata_in <= d;
        @(posedge mclk_in);
        while (hready_in !== 1'b1) @(posedge mclk_in);
        q = hrdata_out;
        @(posedge mclk_in);
        #1;
    endtask

    // wait edges, then step off the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // one-cycle wake-up event (k[0]) and/or accel sample (k[1]), then three quiet cycles
    task automatic pulse(input logic [1:0] k);
        basic_event_in <= {4'h0, k[0], 1'b0};
        accel_ready_in <= k[1];
        tick(1);
        basic_event_in <= 6'h00;
        accel_ready_in <= 1'b0;
        tick(3);
    endtask

    // reference routing model: active state per pin {first, second}
    function automatic logic [1:0] exp_act();
        logic mv, a1, a2;
        mv = (src[4] & rt[3][0]) | (src[5] & cfg[8]) | (src[6] & cfg[9]);
        a1 = (|(src[3:0] & rt[0][6:3])) | (src[7] & rt[1][1]) | (cfg[3] & mv);
        a2 = (|(src[3:0] & rt[2][6:3])) | (src[7] & rt[3][1]) | (~cfg[3] & mv);
        if (src[8] & ~cfg[2])
            return 2'b00;
        return {a1, a2};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs about thirteen hundred cycles, allow twenty thousand
    initial
    begin
        #200000;
        miscompares = miscompares + 1;
        end_of_test();
    end

    // main sequence
    initial
    begin
        {mclk_in, resetn_in, hsel_in, hwrite_in, haddr_in, hwdata_in, htrans_in} = '0;
        {basic_event_in, fifo_flag_in, i3c_mode_in, embedded_event_in, embedded_running_in} = '0;
        {stamp_overflow_in, temperature_ready_in, frontend_ready_in, accel_ready_in} = '0;
        {gyro_ready_in, gyro_high_read_in, accel_high_read_in, cfg, src} = '0;
        hsize_in = 3'b010;
        accel_active_in = 1'b1;
        seed = 32'h8aee;
        miscompares = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk_in);
        resetn_in <= 1'b1;
        tick(1);
        chk(32'({hresp_out, line1, line2, first_irq_pin_oe_out, second_irq_pin_oe_out}), 32'h3);
        for (j = 0; j < 5; j++)
        begin
            bus(8'(4 * j), 1'b0, 32'h0);
            chk(q, 32'h0);
        end
        bus(8'h40, 1'b1, 32'hffffffff);
        bus(8'h40, 1'b0, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        // random routing, polarity, drive and redirect against the reference model
        for (i = 0; i < 40; i++)
        begin
            for (j = 0; j < 4; j++)
            begin
                rt[j] = 8'($random(seed)) & ((j == 2) ? 8'h7f : 8'hff) & MSK[j];
                bus(8'(4 * j), 1'b1, {24'h0, rt[j] | ~MSK[j]});
                bus(8'(4 * j), 1'b0, 32'h0);
                chk(q, {24'h0, rt[j]});
            end
            cfg = 10'($random(seed));
            bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
            for (e = 0; e < 3; e++)
            begin
                src = 9'($random(seed));
                {i3c_mode_in, embedded_event_in, frontend_ready_in, temperature_ready_in,
                 stamp_overflow_in, fifo_flag_in} <= src;
                tick(1);
                chk(32'({line1, line2}), 32'({2{cfg[0]}} ^ exp_act()));
                chk(32'({first_irq_pin_oe_out, second_irq_pin_oe_out}), cfg[1] ? 32'(exp_act()) : 32'h3);
            end
        end
        {i3c_mode_in, embedded_event_in, frontend_ready_in, temperature_ready_in,
         stamp_overflow_in, fifo_flag_in} <= 9'h000;
        bus(8'h00, 1'b1, 32'h0);
        bus(8'h08, 1'b1, 32'h0);
        bus(8'h0c, 1'b1, 32'h0);
        $display("test routing done");
        // latching and its clearing reads
        cfg = 10'h050;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        bus(8'h04, 1'b1, 32'h20);
        pulse(2'b01);
        chk(32'(line1), 32'h1);
        bus(imupr_pkg::OFS_AGGREGATE, 1'b0, 32'h0);
        chk(q & 32'h2, 32'h2);
        chk(32'(line1), 32'h0);
        cfg = 10'h070;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        pulse(2'b01);
        bus(imupr_pkg::OFS_AGGREGATE, 1'b0, 32'h0);
        chk(32'(line1), 32'h1);
        bus(imupr_pkg::OFS_WAKE_SRC, 1'b0, 32'h0);
        chk(q & 32'h2, 32'h2);
        chk(32'(line1), 32'h0);
        bus(8'h04, 1'b1, 32'h0);
        pulse(2'b01);
        bus(8'h04, 1'b1, 32'h20);
        chk(32'(line1), 32'h0);
        cfg = 10'h040;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        basic_event_in <= 6'h02;
        tick(1);
        chk(32'(line1), 32'h1);
        accel_active_in <= 1'b0;
        tick(1);
        chk(32'(line1), 32'h0);
        accel_active_in <= 1'b1;
        cfg = 10'h000;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        chk(32'(line1), 32'h0);
        basic_event_in <= 6'h00;
        $display("test latching done");
        // end-of-operation mode on the second pin, then redirected to the first pin
        bus(8'h08, 1'b1, 32'h80);
        embedded_running_in <= 1'b1;
        tick(1);
        chk(32'(line2), 32'h0);
        embedded_running_in <= 1'b0;
        tick(1);
        chk(32'(line2), 32'h1);
        cfg = 10'h008;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        chk(32'({line1, line2}), 32'h2);
        bus(8'h08, 1'b1, 32'h0);
        $display("test end-of-operation done");
        // data-ready latched, then pulsed
        bus(8'h00, 1'b1, 32'h1);
        pulse(2'b10);
        chk(32'(line1), 32'h1);
        accel_high_read_in <= 1'b1;
        tick(1);
        accel_high_read_in <= 1'b0;
        tick(1);
        chk(32'(line1), 32'h0);
        cfg = 10'h080;
        bus(imupr_pkg::OFS_PIN_CONFIG, 1'b1, {22'h0, cfg});
        pulse(2'b10);
        chk(32'(line1), 32'h1);
        tick(PULSE);
        chk(32'(line1), 32'h0);
        bus(imupr_pkg::OFS_DRDY_STATUS, 1'b0, 32'h0);
        chk(q & 32'h1, 32'h1);
        $display("test data-ready done");
        end_of_test();
    end
endmodule // imu_interrupt_pin_router_test

// *** testbench/imupr_host_model.sv ***
// host side: the two interrupt wires as the microcontroller sees them
`timescale 1ns/10ps
module imupr_host_model (
    input  wire logic first_pin_in,
    input  wire logic first_oe_in,
    input  wire logic second_pin_in,
    input  wire logic second_oe_in,
    input  wire logic pol_low_in,
    output logic      first_line_out,
    output logic      second_line_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // an undriven wire is pulled to the idle level, so open drain still reads cleanly
    assign first_line_out  = first_oe_in ? first_pin_in : pol_low_in;
    assign second_line_out = second_oe_in ? second_pin_in : pol_low_in;
endmodule // imupr_host_model
